// *** verilog/scg_ctrl_top.sv ***
// Sleep mode and clock gating controller, Wishbone slave
// Assumes core pulses sleep_instr_in, wake inputs are enabled requests
`timescale 1ns/100ps
`include "scg_consts.svh"
module scg_ctrl_top #(
  parameter int AW = 10,
  parameter int CW = 3
) (
  // Clock and reset
  input  wire logic          clk_sys_in,
  input  wire logic          nrst_in,
  // Wishbone slave
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [AW-1:0] wb_adr_in,
  input  wire logic [3:0]    wb_sel_in,
  input  wire logic [31:0]   wb_dat_in,
  output logic      [31:0]   wb_dat_out,
  output logic               wb_ack_out,
  // Core side
  input  wire logic          sleep_instr_in,
  input  wire logic          core_reset_req_in,
  output logic               core_hold_out,
  output logic               wake_irq_out,
  output logic               reset_vector_out,
  // Wake sources
  input  wire logic          ext_level_irq_in,
  input  wire logic          ext_edge_irq_in,
  input  wire logic          pin_change_irq_in,
  input  wire logic          conv_irq_in,
  input  wire logic          wdt_irq_in,
  input  wire logic          supply_irq_in,
  input  wire logic          other_irq_in,
  // Converter
  input  wire logic          conv_enabled_in,
  input  wire logic          conv_begin_in,
  output logic               conv_start_out,
  output logic               ext_conv_out,
  output logic               comp_mux_block_out,
  // Clock enables
  output logic               core_clk_en_out,
  output logic               nvmem_clk_en_out,
  output logic               periph_clk_en_out,
  output logic               conv_clk_en_out,
  output logic               osc_en_out,
  output logic               timer_clk_en_out,
  output logic               conv_periph_clk_en_out,
  // Power side controls
  output logic               comparator_off_out,
  output logic               input_buf_en_out,
  output logic               wake_buf_en_out,
  output logic      [1:0]    periph_reg_block_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [AW-3:0] IDX_GATE  = `SCG_IDX_GATE;
  localparam logic [AW-3:0] IDX_SLEEP = `SCG_IDX_SLEEP;
  localparam logic [AW-3:0] IDX_STAT  = `SCG_IDX_STAT;

  scg_pkg::scg_state_t    state_r;
  scg_pkg::scg_state_t    state_nxt;
  logic [2:0]             kind_r;
  logic [2:0]             kind_nxt;
  logic [1:0]             gate_r;
  logic [3:0]             sleep_r;
  logic [6:0]             wake_src;
  logic                   enter;
  logic                   wake;
  logic                   req;
  logic                   wr_go;
  logic [AW-3:0]          idx;
  logic [7:0]             rd_mux;
  logic                   conv_en_prev_r;
  scg_pkg::scg_clk_mask_t mask_nxt;

  scg_tmr_if #(.CW(CW)) tmr_bus ();

  scg_wake_timer #(.CW(CW)) u_timer (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .tmr        (tmr_bus)
  );

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function automatic logic kind_valid(input logic [2:0] k);
    kind_valid = (k == `SCG_KIND_IDLE) || (k == `SCG_KIND_NOISE) ||
                 (k == `SCG_KIND_PDOWN) || (k == `SCG_KIND_STBY);
  endfunction : kind_valid

  // Sources {other, supply, wdt, conv, pin, edge, level}
  function automatic logic wake_ok(input logic [2:0] k, input logic [6:0] s);
    if (k == `SCG_KIND_IDLE) begin
      wake_ok = |s;
    end else if (k == `SCG_KIND_NOISE) begin
      wake_ok = s[0] | s[2] | s[3] | s[4] | s[5];
    end else begin
      wake_ok = s[0] | s[2] | s[4];
    end
  endfunction : wake_ok

  function automatic scg_pkg::scg_clk_mask_t clk_mask(
    input scg_pkg::scg_state_t st,
    input logic [2:0]          k
  );
    unique case (st)
      scg_pkg::st_active,
      scg_pkg::st_hold: clk_mask = `SCG_MASK_ALL;
      scg_pkg::st_osc: clk_mask = `SCG_MASK_OSC;
      scg_pkg::st_sleep: begin
        if (k == `SCG_KIND_IDLE) begin
          clk_mask = `SCG_MASK_IDLE;
        end else if (k == `SCG_KIND_NOISE) begin
          clk_mask = `SCG_MASK_NOISE;
        end else if (k == `SCG_KIND_STBY) begin
          clk_mask = `SCG_MASK_STBY;
        end else begin
          clk_mask = `SCG_MASK_PDOWN;
        end
      end
    endcase
  endfunction : clk_mask

  // ----------------------------------------
  // Sleep entry and wake decision
  // ----------------------------------------
  assign wake_src = {other_irq_in, supply_irq_in, wdt_irq_in, conv_irq_in,
                     pin_change_irq_in, ext_edge_irq_in, ext_level_irq_in};

  assign enter = (state_r == scg_pkg::st_active) && sleep_instr_in &&
                 sleep_r[`SCG_ARM_BIT] &&
                 kind_valid(sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB]);

  assign wake = wake_ok(kind_r, wake_src);

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always_comb begin
    state_nxt     = state_r;
    kind_nxt      = kind_r;
    tmr_bus.load  = 1'b0;
    tmr_bus.count = '0;
    unique case (state_r)
      scg_pkg::st_active: begin
        if (enter) begin
          state_nxt = scg_pkg::st_sleep;
          kind_nxt  = sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB];
        end
      end
      scg_pkg::st_sleep: begin
        if (core_reset_req_in) begin
          state_nxt = scg_pkg::st_active;
        end else if (wake) begin
          tmr_bus.load = 1'b1;
          if (kind_r == `SCG_KIND_PDOWN) begin
            state_nxt     = scg_pkg::st_osc;
            tmr_bus.count = CW'(`SCG_OSC_START_CYC);
          end else begin
            state_nxt     = scg_pkg::st_hold;
            tmr_bus.count = CW'(`SCG_HOLD_CYC);
          end
        end
      end
      scg_pkg::st_osc: begin
        if (tmr_bus.done) begin
          state_nxt     = scg_pkg::st_hold;
          tmr_bus.load  = 1'b1;
          tmr_bus.count = CW'(`SCG_HOLD_CYC);
        end
      end
      scg_pkg::st_hold: begin
        if (tmr_bus.done) begin
          state_nxt = scg_pkg::st_active;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= scg_pkg::st_active;
      kind_r  <= `SCG_KIND_IDLE;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req   = wb_cyc_in & wb_stb_in;
  assign idx   = wb_adr_in[AW-1:2];
  assign wr_go = req & wb_we_in & wb_ack_out & wb_sel_in[0];

  always_comb begin
    unique case (idx)
      IDX_GATE:  rd_mux = {6'h00, gate_r};
      IDX_SLEEP: rd_mux = {4'h0, sleep_r};
      IDX_STAT:  rd_mux = {4'h0, kind_valid(sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB]),
                           ext_conv_out, state_r};
      default:   rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req & ~wb_ack_out;
      wb_dat_out <= (req & ~wb_ack_out) ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  // Gate register, writes take effect with the ack
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_r <= `SCG_GATE_RST;
    end else if (wr_go && (idx == IDX_GATE)) begin
      gate_r <= wb_dat_in[1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleep_r <= `SCG_SLEEP_RST;
    end else if (wr_go && (idx == IDX_SLEEP)) begin
      sleep_r <= wb_dat_in[3:0];
    end
  end

  // ----------------------------------------
  // Clock enables
  // ----------------------------------------
  assign mask_nxt = clk_mask(state_nxt, kind_nxt);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_clk_en_out   <= 1'b1;
      nvmem_clk_en_out  <= 1'b1;
      periph_clk_en_out <= 1'b1;
      conv_clk_en_out   <= 1'b1;
      osc_en_out        <= 1'b1;
    end else begin
      core_clk_en_out   <= mask_nxt[0];
      nvmem_clk_en_out  <= mask_nxt[1];
      periph_clk_en_out <= mask_nxt[2];
      conv_clk_en_out   <= mask_nxt[3];
      osc_en_out        <= mask_nxt[4];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_clk_en_out       <= 1'b1;
      conv_periph_clk_en_out <= 1'b1;
      periph_reg_block_out   <= 2'h0;
    end else begin
      timer_clk_en_out       <= mask_nxt[2] & ~gate_r[`SCG_TMR_BIT];
      conv_periph_clk_en_out <= mask_nxt[3] & ~gate_r[`SCG_CONV_BIT];
      periph_reg_block_out   <= gate_r;
    end
  end

  // ----------------------------------------
  // Core handshake
  // ----------------------------------------
  // hold then interrupt
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_hold_out    <= 1'b0;
      wake_irq_out     <= 1'b0;
      reset_vector_out <= 1'b0;
    end else begin
      core_hold_out    <= (state_nxt == scg_pkg::st_hold);
      wake_irq_out     <= (state_r == scg_pkg::st_hold) && tmr_bus.done;
      reset_vector_out <= (state_r == scg_pkg::st_sleep) && core_reset_req_in;
    end
  end

  // ----------------------------------------
  // Converter and comparator
  // ----------------------------------------
  // conversion on entry
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conv_start_out <= 1'b0;
      conv_en_prev_r <= 1'b0;
      ext_conv_out   <= 1'b0;
    end else begin
      conv_start_out <= enter && conv_enabled_in && !gate_r[`SCG_CONV_BIT] &&
                        ((sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB] == `SCG_KIND_IDLE) ||
                         (sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB] == `SCG_KIND_NOISE));
      conv_en_prev_r <= conv_enabled_in;
      if (conv_enabled_in && !conv_en_prev_r) begin
        ext_conv_out <= 1'b1;
      end else if (conv_begin_in) begin
        ext_conv_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      comp_mux_block_out <= 1'b0;
      comparator_off_out <= 1'b0;
      input_buf_en_out   <= 1'b1;
      wake_buf_en_out    <= 1'b1;
    end else begin
      comp_mux_block_out <= gate_r[`SCG_CONV_BIT];
      comparator_off_out <= (state_nxt == scg_pkg::st_osc) ||
                            ((state_nxt == scg_pkg::st_sleep) &&
                             (kind_nxt == `SCG_KIND_PDOWN));
      input_buf_en_out   <= mask_nxt[2];
      wake_buf_en_out    <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_noop_sleep : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_active && sleep_instr_in && (!sleep_r[`SCG_ARM_BIT] ||
     !kind_valid(sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB])))
    |=> (state_r == scg_pkg::st_active) && core_clk_en_out)
    else $error("sleep without arm or with reserved kind gated clocks");

  a_armed_entry : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    enter |=> (state_r == scg_pkg::st_sleep) && !core_clk_en_out)
    else $error("armed sleep not entered");

  a_hold_len : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(core_hold_out) |-> core_hold_out[*4] ##1 (!core_hold_out && wake_irq_out))
    else $error("core hold not four cycles");

  a_osc_start : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_PDOWN && wake && !core_reset_req_in)
    |=> (state_r == scg_pkg::st_osc)[*6] ##1 (state_r == scg_pkg::st_hold))
    else $error("oscillator start-up not six cycles");

  a_no_osc_wait : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r != `SCG_KIND_PDOWN && wake && !core_reset_req_in)
    |=> core_hold_out && osc_en_out)
    else $error("start-up delay outside power-down");

  a_idle_clocks : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_IDLE)
    |-> !core_clk_en_out && !nvmem_clk_en_out && periph_clk_en_out && conv_clk_en_out && osc_en_out)
    else $error("idle clock set wrong");

  a_noise_clocks : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_NOISE)
    |-> !periph_clk_en_out && !core_clk_en_out && conv_clk_en_out && osc_en_out && !input_buf_en_out)
    else $error("noise reduction clock set wrong");

  a_pdown_clocks : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_PDOWN)
    |-> !osc_en_out && !conv_clk_en_out && !periph_clk_en_out && !core_clk_en_out)
    else $error("power-down clocks running");

  a_stby_osc : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_STBY)
    |-> osc_en_out && !conv_clk_en_out && !periph_clk_en_out && !comparator_off_out)
    else $error("standby differs from power-down wrongly");

  a_cmp_off : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r == `SCG_KIND_PDOWN) |-> comparator_off_out)
    else $error("comparator on in power-down");

  a_deep_wake : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && kind_r != `SCG_KIND_IDLE && kind_r != `SCG_KIND_NOISE &&
     !ext_level_irq_in && !pin_change_irq_in && !wdt_irq_in && !core_reset_req_in)
    |=> state_r == scg_pkg::st_sleep)
    else $error("deep sleep woken by a disallowed source");

  a_conv_start : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (enter && conv_enabled_in && !gate_r[`SCG_CONV_BIT] &&
     sleep_r[`SCG_KIND_MSB:`SCG_KIND_LSB+1] == 2'h0) |=> conv_start_out ##1 !conv_start_out)
    else $error("no conversion started on sleep entry");

  a_reset_wake : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == scg_pkg::st_sleep && core_reset_req_in)
    |=> reset_vector_out && !wake_irq_out && core_clk_en_out)
    else $error("reset during sleep did not wake");

  a_timer_gate : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    gate_r[`SCG_TMR_BIT] |=> !timer_clk_en_out && periph_reg_block_out[`SCG_TMR_BIT])
    else $error("timer clock not stopped by gate");

  a_ext_conv : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(conv_enabled_in) |=> ext_conv_out)
    else $error("re-enabled converter not marked extended");

  a_upper_zero : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (wb_ack_out && $past(idx) == IDX_SLEEP) |-> wb_dat_out[31:4] == 28'h0000000)
    else $error("unused control bits read non-zero");

endmodule : scg_ctrl_top

// *** common/scg_consts.svh ***
// Constants of the sleep and clock gating controller
// Included by the top module only
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SCG_IDX_GATE      8'h35
`define SCG_IDX_SLEEP     8'h3A
`define SCG_IDX_STAT      8'h3B

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define SCG_GATE_RST      2'h0
`define SCG_SLEEP_RST     4'h0
`define SCG_ARM_BIT       0
`define SCG_KIND_LSB      1
`define SCG_KIND_MSB      3
`define SCG_TMR_BIT       0
`define SCG_CONV_BIT      1

// ----------------------------------------
// Sleep kind codes
// ----------------------------------------
`define SCG_KIND_IDLE     3'h0
`define SCG_KIND_NOISE    3'h1
`define SCG_KIND_PDOWN    3'h2
`define SCG_KIND_STBY     3'h4

// ----------------------------------------
// Clock masks {osc, conv, periph, nvmem, core}
// ----------------------------------------
`define SCG_MASK_ALL      5'h1F
`define SCG_MASK_IDLE     5'h1C
`define SCG_MASK_NOISE    5'h18
`define SCG_MASK_STBY     5'h10
`define SCG_MASK_PDOWN    5'h00
`define SCG_MASK_OSC      5'h10

// ----------------------------------------
// Timing in main clock cycles
// ----------------------------------------
`define SCG_OSC_START_CYC 3'h6
`define SCG_HOLD_CYC      3'h4

`endif

// *** common/scg_pkg.sv ***
// Types of the sleep and clock gating controller
// Used by the top module through scoped names only
package scg_pkg;

  // Gray coded along active, sleep, osc start, hold
  typedef enum logic [1:0] {
    st_active = 2'b00,
    st_sleep  = 2'b01,
    st_osc    = 2'b11,
    st_hold   = 2'b10
  } scg_state_t;

  typedef logic [4:0] scg_clk_mask_t;

endpackage : scg_pkg

// *** common/scg_tmr_if.sv ***
// Carrier between the controller and its wake delay timer
// Controller drives load and count, timer answers done
`timescale 1ns/100ps
interface scg_tmr_if #(
  parameter int CW = 3
);
  logic          load;
  logic [CW-1:0] count;
  logic          done;
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface : scg_tmr_if

// *** verilog/scg_wake_timer.sv ***
// Down counter for oscillator start-up and core hold
// Assumes one clock, load pulses come from the controller
`timescale 1ns/100ps
module scg_wake_timer #(
  parameter int CW = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Controller side
  scg_tmr_if.tmr   tmr
);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
    end else if (tmr.load) begin
      cnt_r <= tmr.count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Last cycle of the loaded span
  assign tmr.done = (cnt_r == {{(CW-1){1'b0}}, 1'b1});

endmodule : scg_wake_timer

// *** tb/scg_core_model.sv ***
// Behavioural core and wake sources facing the controller
// Assumes the bench pulses go_in and src_in for one cycle
`timescale 1ns/100ps
module scg_core_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  // Bench side
  input  wire logic       go_in,
  input  wire logic [6:0] src_in,
  // Controller side
  input  wire logic       wake_irq_in,
  input  wire logic       reset_vector_in,
  output logic            sleep_instr_out,
  output logic      [6:0] irq_out
);
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) sleep_instr_out <= 1'b0;
    else sleep_instr_out <= go_in;
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) irq_out <= 7'h00;
    else if (wake_irq_in || reset_vector_in) irq_out <= 7'h00;
    else if (|src_in) irq_out <= src_in;
  end
endmodule : scg_core_model

// *** tb/sleep_and_clock_gating_ctrl_bench.sv ***
// Self-checking bench of the sleep and clock gating controller
// Assumes a core model on the far side and a Wishbone master here
`timescale 1ns/100ps
module sleep_and_clock_gating_ctrl_bench;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        cyc = 1'b0, we = 1'b0, rst_req = 1'b0, conv_en = 1'b0, go = 1'b0, cbeg = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0, rd, dout;
  logic [6:0]  src = 7'h00, irq;
  logic        ack, sleep_i, hold, wirq, rvec, cstart, ext_conv, cmux, core_en, nv_en, pe_en;
  logic        cv_en, osc_en, tmr_en, cvp_en, cmp_off, ib, wkb;
  logic [1:0]  blk;
  int          bad_count = 0, checks_done = 0, n;
  always #4 clk_sys_in = ~clk_sys_in;
  scg_ctrl_top u_dut (.clk_sys_in, .nrst_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack), .sleep_instr_in(sleep_i),
    .core_reset_req_in(rst_req), .core_hold_out(hold), .wake_irq_out(wirq), .reset_vector_out(rvec),
    .ext_level_irq_in(irq[0]), .ext_edge_irq_in(irq[1]), .pin_change_irq_in(irq[2]), .conv_irq_in(irq[3]),
    .wdt_irq_in(irq[4]), .supply_irq_in(irq[5]), .other_irq_in(irq[6]), .conv_enabled_in(conv_en),
    .conv_begin_in(cbeg), .conv_start_out(cstart), .ext_conv_out(ext_conv), .comp_mux_block_out(cmux),
    .core_clk_en_out(core_en), .nvmem_clk_en_out(nv_en), .periph_clk_en_out(pe_en), .conv_clk_en_out(cv_en),
    .osc_en_out(osc_en), .timer_clk_en_out(tmr_en), .conv_periph_clk_en_out(cvp_en),
    .comparator_off_out(cmp_off), .input_buf_en_out(ib), .wake_buf_en_out(wkb), .periph_reg_block_out(blk));
  scg_core_model u_core (.clk_sys_in, .nrst_in, .go_in(go), .src_in(src), .wake_irq_in(wirq),
    .reset_vector_in(rvec), .sleep_instr_out(sleep_i), .irq_out(irq));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk(ack, 1'b1);
    q = dout;
    cyc <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wb
  task enter(input logic [7:0] ctl);
    wb(1'b1, 10'h0E8, {24'h0, ctl}, rd);
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask : enter
  task regs;
    wb(1'b0, 10'h0D4, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, 10'h0D4, 32'hFF, rd);
    wb(1'b0, 10'h0D4, 32'h0, rd);
    chk(rd, 32'h3);
    chk({tmr_en, cvp_en, cmux, blk}, 5'h07);
    wb(1'b1, 10'h0D4, 32'h0, rd);
    wb(1'b0, 10'h3FC, 32'h0, rd);
    chk(rd, 32'h0);
    chk({tmr_en, cvp_en, blk}, 4'hC);
    conv_en <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk(ext_conv, 1'b1);
    cbeg <= 1'b1;
    @(posedge clk_sys_in);
    cbeg <= 1'b0;
    @(posedge clk_sys_in);
    chk(ext_conv, 1'b0);
  endtask : regs
  task noop;
    for (int i = 0; i < 2; i++) begin
      enter(i ? 8'h07 : 8'h04);
      chk({core_en, nv_en}, 2'h3);
    end
  endtask : noop
  task sleep_run(input logic [7:0] ctl, input logic [6:0] m, input logic [4:0] em, input int osc);
    int k;
    enter(ctl);
    chk({osc_en, cv_en, pe_en, nv_en, core_en}, em);
    chk({cstart, cmp_off, ib, wkb}, {ctl[3:1] < 3'h2, ctl[3:1] == 3'h2, em[2], 1'b1});
    src <= m;
    @(posedge clk_sys_in);
    src <= 7'h00;
    n = 1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (hold !== 1'b1 && n < 50);
    chk(32'(n), 32'(3 + osc));
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (wirq !== 1'b1 && k < 50);
    chk(32'(k), 32'd4);
    wb(1'b0, 10'h0E8, 32'h0, rd);
    chk(rd, {28'h0, ctl[3:0]});
    wb(1'b1, 10'h0E8, {24'h0, ctl & 8'hFE}, rd);
  endtask : sleep_run
  task rst_wake;
    enter(8'h09);
    src <= 7'h22;
    @(posedge clk_sys_in);
    src <= 7'h00;
    repeat (8) @(posedge clk_sys_in);
    chk({hold, core_en}, 2'h0);
    rst_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rvec !== 1'b1 && n < 20);
    rst_req <= 1'b0;
    chk({31'(n), wirq}, {31'd2, 1'b0});
  endtask : rst_wake
  task hard_rst;
    enter(8'h05);
    nrst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({osc_en, cv_en, pe_en, nv_en, core_en, ib, wkb, cmp_off}, 8'hFE);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    wb(1'b0, 10'h0E8, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : hard_rst
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    regs;
    noop;
    sleep_run(8'h01, 7'h40, 5'h1C, 0);
    sleep_run(8'h03, 7'h08, 5'h18, 0);
    sleep_run(8'h05, 7'h04, 5'h00, 6);
    sleep_run(8'h09, 7'h10, 5'h10, 0);
    rst_wake;
    hard_rst;
    test_done;
  end
endmodule : sleep_and_clock_gating_ctrl_bench
